// ---- core/spi_mem_pkg.sv ----
// shared constants for the serial memory front end and its master
package spi_mem_pkg;
  // ********************************
  // opcodes (upper nibble zero, bit 3 is don't care)
  // ********************************
  localparam logic [7:0] OP_MASK        = 8'hF7;
  localparam logic [7:0] OP_WR_ENABLE   = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE  = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WR   = 8'h01;
  localparam logic [7:0] OP_READ        = 8'h03;
  localparam logic [7:0] OP_WRITE       = 8'h02;
  // ********************************
  // status register fields
  // ********************************
  localparam int          SR_ARM_BIT  = 7;
  localparam int          SR_BP1_BIT  = 3;
  localparam int          SR_BP0_BIT  = 2;
  localparam int          SR_WEN_BIT  = 1;
  localparam int          SR_BUSY_BIT = 0;
  localparam logic [7:0]  SR_WR_MASK  = 8'h8C;
  localparam logic [7:0]  SR_RESET    = 8'h00;
  localparam logic [7:0]  SR_BUSY_VAL = 8'hFF;
  // ********************************
  // timing
  // ********************************
  localparam int CLK_MHZ       = 250;
  localparam int WRITE_TIME_MS = 5;
  localparam int WRITE_CYCLES  = WRITE_TIME_MS * 1000 * CLK_MHZ;
  localparam int SCK_HALF_DIV  = 4;
  typedef enum logic [1:0] {ST_OPCODE, ST_PAYLOAD, ST_READOUT, ST_DEAD} slave_state_type;
  typedef enum logic [1:0] {M_IDLE, M_SHIFT, M_END} master_state_type;
endpackage

// ---- core/spi_mem_if.sv ----
// serial link between the memory front end and the host master
`timescale 1ns/1ps
interface spi_mem_if;
  logic sck;        // serial clock from master
  logic cs_n;       // chip select, active low
  logic si;         // data into memory
  logic so_o;       // memory output value
  logic so_oe_n;    // memory output enable, low drives
  logic hold_n;     // pause, active low
  logic wp_n;       // write protect, active low
  modport mem (input sck, cs_n, si, hold_n, wp_n, output so_o, so_oe_n);
  modport host (output sck, cs_n, si, hold_n, wp_n, input so_o, so_oe_n);
endinterface

// ---- core/spi_mem_slave.sv ----
// serial memory front end: framing, opcode decode, pause and write protection
`timescale 1ns/1ps
module spi_mem_slave #(
  parameter int WRITE_CYCLES = spi_mem_pkg::WRITE_CYCLES
) (
  input  wire logic core_clk_in,           // system clock
  input  wire logic rstn_in,               // async reset, active low
  input  wire logic clk_en_in,             // freezes state when low
  spi_mem_if.mem    link,                  // serial link
  output logic [7:0] status_out,           // status register, or SR_BUSY_VAL while busy
  output logic [7:0] opcode_out,           // last accepted opcode
  output logic       op_strobe_out,        // pulse when an opcode is accepted
  output logic [7:0] data_out,             // payload byte received
  output logic       data_strobe_out,      // pulse per payload byte
  input  wire logic [7:0] rd_data_in       // array byte loaded into out_reg; never sent, as a read frame stays in ST_PAYLOAD
);
  // ********************************
  // edge detection of link pins
  // ********************************
  logic sck_reg, cs_reg, wp_reg;
  logic busy_reg;
  logic [31:0] wc_cnt_reg;
  logic [7:0] sr_reg;
  logic [7:0] shift_reg, out_reg, op_reg;
  logic [2:0] bit_reg;
  logic       so_en_reg, so_bit_reg, sr_pend_reg;
  logic [7:0] sr_data_reg;
  spi_mem_pkg::slave_state_type st_reg;

  // pins sampled synchronously; the clock pin is only ever read
  wire sck_rise = link.sck & ~sck_reg;
  wire sck_fall = ~link.sck & sck_reg;
  wire cs_fall  = ~link.cs_n & cs_reg;
  wire cs_rise  = link.cs_n & ~cs_reg;
  wire active   = ~link.cs_n & link.hold_n;
  wire [7:0] byte_in = {shift_reg[6:0], link.si};
  wire byte_done = sck_rise & active & (bit_reg == 3'd7);
  wire hw_protect = ~link.wp_n & sr_reg[spi_mem_pkg::SR_ARM_BIT];

  // opcode decoding, used for both validity and class
  function automatic logic op_is(input logic [7:0] b, input logic [7:0] op);
    op_is = ((b & spi_mem_pkg::OP_MASK) == op);
  endfunction
  wire op_valid = op_is(byte_in, spi_mem_pkg::OP_WR_ENABLE) |
                  op_is(byte_in, spi_mem_pkg::OP_WR_DISABLE) |
                  op_is(byte_in, spi_mem_pkg::OP_STATUS_READ) |
                  op_is(byte_in, spi_mem_pkg::OP_STATUS_WR) |
                  op_is(byte_in, spi_mem_pkg::OP_READ) |
                  op_is(byte_in, spi_mem_pkg::OP_WRITE);
  // while busy only the status read gets through
  wire op_take = op_valid &
                 (~busy_reg | op_is(byte_in, spi_mem_pkg::OP_STATUS_READ));
  wire is_status_read_cmd = op_is(byte_in, spi_mem_pkg::OP_STATUS_READ);
  wire is_rd   = op_is(byte_in, spi_mem_pkg::OP_READ);
  wire [7:0] sr_view = busy_reg ? spi_mem_pkg::SR_BUSY_VAL : sr_reg;

  // ********************************
  // pin history
  // ********************************
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sck_reg <= 1'b0;
      cs_reg  <= 1'b1;
      wp_reg  <= 1'b1;
    end else if (clk_en_in) begin
      sck_reg <= link.sck;
      cs_reg  <= link.cs_n;
      wp_reg  <= link.wp_n;
    end
  end

  // ********************************
  // serial sequencer
  // ********************************
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg          <= spi_mem_pkg::ST_OPCODE;
      bit_reg         <= 3'd0;
      shift_reg       <= 8'h00;
      op_reg          <= 8'h00;
      out_reg         <= 8'h00;
      op_strobe_out   <= 1'b0;
      data_strobe_out <= 1'b0;
      data_out        <= 8'h00;
    end else if (clk_en_in) begin
      op_strobe_out   <= 1'b0;
      data_strobe_out <= 1'b0;
      if (cs_fall) begin
        st_reg  <= spi_mem_pkg::ST_OPCODE;
        bit_reg <= 3'd0;
      end else if (sck_rise && active && st_reg != spi_mem_pkg::ST_DEAD) begin
        shift_reg <= byte_in;
        bit_reg   <= bit_reg + 3'd1;
        if (byte_done) begin
          case (st_reg)
            spi_mem_pkg::ST_OPCODE: begin
              if (op_take) begin
                op_reg        <= byte_in;
                op_strobe_out <= 1'b1;
                if (is_status_read_cmd) begin
                  st_reg  <= spi_mem_pkg::ST_READOUT;
                  out_reg <= sr_view;
                end else if (is_rd) begin
                  st_reg <= spi_mem_pkg::ST_PAYLOAD;
                end else begin
                  st_reg <= spi_mem_pkg::ST_PAYLOAD;
                end
              end else begin
                st_reg <= spi_mem_pkg::ST_DEAD;
              end
            end
            spi_mem_pkg::ST_READOUT: begin
              out_reg <= op_is(op_reg, spi_mem_pkg::OP_STATUS_READ) ? sr_view : rd_data_in;
            end
            default: begin
              data_out        <= byte_in;
              data_strobe_out <= 1'b1;
              out_reg         <= rd_data_in;
            end
          endcase
        end
      end
    end
  end

  // ********************************
  // output driver, changes on falling clock edge
  // ********************************
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      so_en_reg  <= 1'b0;
      so_bit_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (cs_fall || link.cs_n) begin
        so_en_reg <= 1'b0;
      end else if (sck_fall && link.hold_n && st_reg == spi_mem_pkg::ST_READOUT) begin
        so_en_reg  <= 1'b1;
        so_bit_reg <= out_reg[3'd7 - bit_reg];
      end else if (st_reg == spi_mem_pkg::ST_DEAD) begin
        so_en_reg <= 1'b0;
      end
    end
  end
  assign link.so_o    = so_bit_reg;
  assign link.so_oe_n = ~(so_en_reg & active);

  // ********************************
  // status write and timed cycle
  // ********************************
  wire sr_op = op_is(op_reg, spi_mem_pkg::OP_STATUS_WR);
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sr_reg      <= spi_mem_pkg::SR_RESET;
      busy_reg    <= 1'b0;
      wc_cnt_reg  <= 32'd0;
      sr_pend_reg <= 1'b0;
      sr_data_reg <= 8'h00;
    end else if (clk_en_in) begin
      if (cs_fall) begin
        sr_pend_reg <= 1'b0;
      end else if (byte_done && st_reg == spi_mem_pkg::ST_PAYLOAD && sr_op) begin
        sr_pend_reg <= ~hw_protect & sr_reg[spi_mem_pkg::SR_WEN_BIT];
        sr_data_reg <= byte_in;
      end else if (~link.wp_n && wp_reg && ~link.cs_n &&
                   sr_reg[spi_mem_pkg::SR_ARM_BIT]) begin
        sr_pend_reg <= 1'b0;
      end
      // write starts at deselect; afterwards the pin no longer matters
      if (cs_rise && sr_pend_reg && ~hw_protect && ~busy_reg) begin
        sr_reg <= (sr_reg & ~spi_mem_pkg::SR_WR_MASK) |
                  (sr_data_reg & spi_mem_pkg::SR_WR_MASK);
        sr_reg[spi_mem_pkg::SR_WEN_BIT] <= 1'b0;
        sr_pend_reg <= 1'b0;
        busy_reg    <= 1'b1;
        wc_cnt_reg  <= 32'(WRITE_CYCLES);
      end else if (busy_reg) begin
        if (wc_cnt_reg <= 32'd1) begin
          busy_reg <= 1'b0;
        end
        wc_cnt_reg <= wc_cnt_reg - 32'd1;
      end else if (cs_rise && !busy_reg) begin
        if (op_is(op_reg, spi_mem_pkg::OP_WR_ENABLE) && st_reg == spi_mem_pkg::ST_PAYLOAD)
          sr_reg[spi_mem_pkg::SR_WEN_BIT] <= 1'b1;
        else if (op_is(op_reg, spi_mem_pkg::OP_WR_DISABLE) && st_reg == spi_mem_pkg::ST_PAYLOAD)
          sr_reg[spi_mem_pkg::SR_WEN_BIT] <= 1'b0;
      end
    end
  end
  assign status_out = sr_view;
  assign opcode_out = op_reg;
endmodule

// ---- core/spi_mem_master.sv ----
// host master: drives clock, select, pause and protect, sends and receives bytes
`timescale 1ns/1ps
module spi_mem_master #(
  parameter int HALF_DIV = spi_mem_pkg::SCK_HALF_DIV
) (
  input  wire logic core_clk_in,           // system clock
  input  wire logic rstn_in,               // async reset, active low
  input  wire logic clk_en_in,             // freezes state when low
  spi_mem_if.host   link,                  // serial link
  input  wire logic       start_in,        // begin selected frame
  input  wire logic       stop_in,         // end frame after current byte
  input  wire logic [7:0] tx_in,           // byte to send
  input  wire logic       tx_valid_in,     // tx byte present
  output logic            tx_ready_out,    // byte accepted
  output logic [7:0]      rx_out,          // byte received
  output logic            rx_valid_out,    // pulse per received byte
  input  wire logic       pause_in,        // request pause
  input  wire logic       wp_n_in,         // protect level to drive
  output logic            busy_out         // frame open
);
  spi_mem_pkg::master_state_type st_reg;
  logic [7:0] div_reg, tx_reg, rx_reg;
  logic [2:0] bit_reg;
  logic sck_reg, cs_reg, hold_reg, loaded_reg;
  wire tick = (div_reg == 8'(HALF_DIV - 1));

  // ********************************
  // frame and bit engine, mode 0
  // ********************************
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= spi_mem_pkg::M_IDLE;
      div_reg <= 8'h00;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      bit_reg <= 3'd0;
      sck_reg <= 1'b0;
      cs_reg <= 1'b1;
      hold_reg <= 1'b1;
      loaded_reg <= 1'b0;
      rx_out <= 8'h00;
      rx_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      rx_valid_out <= 1'b0;
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
      case (st_reg)
        spi_mem_pkg::M_IDLE: begin
          if (start_in) begin
            cs_reg <= 1'b0;
            st_reg <= spi_mem_pkg::M_SHIFT;
          end
        end
        spi_mem_pkg::M_SHIFT: begin
          if (!loaded_reg && tx_valid_in) begin
            tx_reg <= tx_in;
            loaded_reg <= 1'b1;
          end else if (!loaded_reg && stop_in && !sck_reg) begin
            st_reg <= spi_mem_pkg::M_END;
          end else if (tick && !sck_reg) begin
            hold_reg <= ~pause_in;
            if (!pause_in && hold_reg && loaded_reg)
              sck_reg <= 1'b1;
          end else if (tick && sck_reg) begin
            sck_reg <= 1'b0;
            rx_reg <= {rx_reg[6:0], link.so_o};
            tx_reg <= {tx_reg[6:0], 1'b0};
            bit_reg <= bit_reg + 3'd1;
            if (bit_reg == 3'd7) begin
              rx_out <= {rx_reg[6:0], link.so_o};
              rx_valid_out <= 1'b1;
              loaded_reg <= 1'b0;
            end
          end
        end
        default: begin
          cs_reg <= 1'b1;
          hold_reg <= 1'b1;
          st_reg <= spi_mem_pkg::M_IDLE;
        end
      endcase
    end
  end
  assign tx_ready_out = (st_reg == spi_mem_pkg::M_SHIFT) & ~loaded_reg;
  assign link.sck = sck_reg;
  assign link.cs_n = cs_reg;
  assign link.si = tx_reg[7];
  assign link.hold_n = hold_reg;
  assign link.wp_n = wp_n_in;
  assign busy_out = ~cs_reg;
endmodule

// ---- verif/spi_mem_link_sva.sv ----
// checker for the serial link between the memory front end and its master
`timescale 1ns/1ps
module spi_mem_link_sva (
  input  wire logic core_clk_in,  // system clock
  input  wire logic rstn_in,      // async reset, active low
  input  wire logic sck,          // serial clock
  input  wire logic cs_n,         // select, active low
  input  wire logic si,           // data into memory
  input  wire logic so_o,         // memory data
  input  wire logic so_oe_n,      // low while memory drives
  input  wire logic hold_n,       // pause, active low
  input  wire logic wp_n          // protect, active low
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // ************************************
  // opcode tracker
  // ************************************
  logic       sck_d;     // clock pin one cycle back
  logic [3:0] bit_cnt;   // rising edges seen in this frame, stops at 8
  logic [7:0] op_shift;  // opcode bits so far
  logic       bad_op;    // first byte was not a known opcode
  wire  [7:0] op_word  = {op_shift[6:0], si};
  wire        op_known = ((op_word & spi_mem_pkg::OP_MASK) == spi_mem_pkg::OP_WR_ENABLE) |
                         ((op_word & spi_mem_pkg::OP_MASK) == spi_mem_pkg::OP_WR_DISABLE) |
                         ((op_word & spi_mem_pkg::OP_MASK) == spi_mem_pkg::OP_STATUS_READ) |
                         ((op_word & spi_mem_pkg::OP_MASK) == spi_mem_pkg::OP_STATUS_WR) |
                         ((op_word & spi_mem_pkg::OP_MASK) == spi_mem_pkg::OP_READ) |
                         ((op_word & spi_mem_pkg::OP_MASK) == spi_mem_pkg::OP_WRITE);
  // mirrors the pins as the memory sees them, so only whole opcodes are judged
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sck_d    <= 1'b0;
      bit_cnt  <= 4'h0;
      op_shift <= 8'h00;
      bad_op   <= 1'b0;
    end else begin
      sck_d <= sck;
      if (cs_n) begin
        bit_cnt <= 4'h0;
        bad_op  <= 1'b0;
      end else if (sck && !sck_d && hold_n && bit_cnt < 4'h8) begin
        op_shift <= op_word;
        bit_cnt  <= bit_cnt + 4'h1;
        if (bit_cnt == 4'h7) begin
          bad_op <= ~op_known;
        end
      end
    end
  end
  // ************************************
  // link sequences
  // ************************************
  // three cycles of margin let the output enable lag its cause by a register
  sequence s_desel; cs_n [*3]; endsequence
  sequence s_paused; !hold_n [*3]; endsequence
  sequence s_select; $fell(cs_n); endsequence
  sequence s_out_on; $fell(so_oe_n); endsequence
  // ************************************
  // assertions
  // ************************************
  AST_DESEL_FLOAT: assert property (s_desel |-> so_oe_n)
    else $error("so driven while deselected");
  AST_PAUSE_FLOAT: assert property (s_paused |-> so_oe_n)
    else $error("so driven while paused");
  AST_PAUSE_ENTER: assert property ($fell(hold_n) |-> !sck)
    else $error("pause entered with clock high");
  AST_PAUSE_LEAVE: assert property ($rose(hold_n) |-> !sck)
    else $error("pause left with clock high");
  AST_OPCODE_QUIET: assert property (s_select |-> so_oe_n [*8])
    else $error("so driven during opcode byte");
  AST_OUT_SELECTED: assert property (s_out_on |-> !cs_n && hold_n)
    else $error("so enabled outside an active frame");
  AST_IDLE_CLK_LOW: assert property (cs_n [*2] |-> !sck)
    else $error("clock high while deselected");
  AST_SO_FALL_ONLY: assert property (!so_oe_n && $past(!so_oe_n) && sck && $past(sck)
    |-> $stable(so_o))
    else $error("so changed while clock high");
  AST_BAD_OP_FLOAT: assert property (bad_op |-> so_oe_n)
    else $error("so driven after an unknown opcode");
  AST_OPCODE_FLOAT: assert property (!cs_n && bit_cnt < 4'h8 |-> so_oe_n)
    else $error("so driven before the opcode ended");
endmodule

// ---- verif/spi_eeprom_slave_front_end_test.sv ----
// testbench: master and memory front end facing each other on one link
`timescale 1ns/1ps
module spi_eeprom_slave_front_end_test;
  logic       core_clk_in = 1'b0;
  logic       rstn_in = 1'b0;
  logic       start_req = 1'b0, stop_req = 1'b0, tx_valid = 1'b0;
  logic       pause_req = 1'b0, wp_level = 1'b1;
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] rx_byte, status, opcode, rx, data_byte;
  logic       tx_ready, rx_valid, busy, op_pulse, data_pulse;
  int         bad_count = 0;
  int         num_checks = 0;
  int         op_cnt = 0;
  int         data_cnt = 0;
  spi_mem_if link ();
  // short write time keeps the busy window shorter than the 250-cycle waits that follow
  spi_mem_slave #(.WRITE_CYCLES(200)) spi_mem_slave_i (.core_clk_in(core_clk_in),
    .rstn_in(rstn_in), .clk_en_in(1'b1), .link(link), .status_out(status),
    .opcode_out(opcode), .op_strobe_out(op_pulse), .data_out(data_byte),
    .data_strobe_out(data_pulse), .rd_data_in(8'h5A));
  spi_mem_master spi_mem_master_i (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .clk_en_in(1'b1), .link(link), .start_in(start_req), .stop_in(stop_req),
    .tx_in(tx_byte), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .rx_out(rx_byte),
    .rx_valid_out(rx_valid), .pause_in(pause_req), .wp_n_in(wp_level), .busy_out(busy));
  spi_mem_link_sva spi_mem_link_sva_i (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .sck(link.sck), .cs_n(link.cs_n), .si(link.si), .so_o(link.so_o),
    .so_oe_n(link.so_oe_n), .hold_n(link.hold_n), .wp_n(link.wp_n));
  // ************************************
  // clock, compare and verdict
  // ************************************
  always #2 core_clk_in = ~core_clk_in;
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // a wait that hits its limit is a mismatch, never a silent pass
  task automatic chk_wait(input string name, input int k, input int lim);
    num_checks++;
    if (k >= lim) begin
      bad_count++;
      $display("ERROR %s expected wait below %0d seen %0d", name, lim, k);
    end
  endtask
  // each strobe stands one cycle, so one falling edge sees it once
  always @(negedge core_clk_in) begin
    if (op_pulse === 1'b1) op_cnt++;
    if (data_pulse === 1'b1) data_cnt++;
  end
  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ************************************
  // one selected frame of n bytes; ev 1 pauses, ev 2 drops protect in byte two
  // ************************************
  task automatic frame(input logic [7:0] op, input logic [7:0] pay, input int n,
                       input int ev, output logic [7:0] got);
    int k;
    @(negedge core_clk_in) start_req = 1'b1;
    @(negedge core_clk_in) start_req = 1'b0;
    for (int i = 0; i < n; i++) begin
      // a byte is offered on a falling edge, never in the step of a rising one
      @(negedge core_clk_in);
      tx_byte = (i == 0) ? op : pay;
      tx_valid = 1'b1;
      k = 0;
      do begin @(posedge core_clk_in); k++; end while (tx_ready !== 1'b1 && k < 200);
      chk_wait("tx ready", k, 200);
      @(negedge core_clk_in) tx_valid = 1'b0;
      repeat (9) @(negedge core_clk_in);
      if (i == 1 && ev == 1) begin
        pause_req = 1'b1;
        repeat (40) @(negedge core_clk_in);
        pause_req = 1'b0;
      end
      if (i == 1 && ev == 2) wp_level = 1'b0;
      k = 0;
      do begin @(posedge core_clk_in); k++; end while (rx_valid !== 1'b1 && k < 400);
      chk_wait("rx valid", k, 400);
      got = rx_byte;
    end
    @(negedge core_clk_in) stop_req = 1'b1;
    k = 0;
    do begin @(negedge core_clk_in); k++; end while (busy !== 1'b0 && k < 50);
    chk_wait("deselect", k, 50);
    stop_req = 1'b0;
  endtask
  // the status write frames are always preceded by a write enable frame
  task automatic wr_status(input logic [7:0] val, input int ev);
    frame(spi_mem_pkg::OP_WR_ENABLE, 8'h00, 1, 0, rx);
    frame(spi_mem_pkg::OP_STATUS_WR, val, 2, ev, rx);
  endtask
  // ************************************
  // watchdog and main sequence
  // ************************************
  initial begin
    repeat (20000) @(posedge core_clk_in);
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (2) @(negedge core_clk_in);
    rstn_in = 1'b1;
    frame(spi_mem_pkg::OP_STATUS_READ, 8'h00, 2, 0, rx);
    chk8("status", 8'h00, rx);
    chk8("opcode", spi_mem_pkg::OP_STATUS_READ, opcode);
    frame(spi_mem_pkg::OP_WR_ENABLE, 8'h00, 1, 0, rx);
    frame(spi_mem_pkg::OP_STATUS_READ, 8'h00, 2, 0, rx);
    chk8("wen", 8'h02, rx);
    wp_level = 1'b0;
    wr_status(8'h8C, 0);
    chk8("payload", 8'h8C, data_byte);
    repeat (2) @(negedge core_clk_in);
    chk8("busy view", 8'hFF, status);
    frame(spi_mem_pkg::OP_STATUS_READ, 8'h00, 2, 0, rx);
    chk8("busy read", 8'hFF, rx);
    repeat (250) @(negedge core_clk_in);
    chk8("armed", 8'h8C, status);
    wr_status(8'h00, 0);
    repeat (250) @(negedge core_clk_in);
    chk8("locked", 8'h8C, status & 8'h8C);
    wp_level = 1'b1;
    wr_status(8'h00, 2);
    wp_level = 1'b1;
    repeat (250) @(negedge core_clk_in);
    chk8("aborted", 8'h8C, status & 8'h8C);
    wr_status(8'h04, 0);
    repeat (2) @(negedge core_clk_in);
    wp_level = 1'b0;
    // a write enable sent while the timed write runs must be dropped
    frame(spi_mem_pkg::OP_WR_ENABLE, 8'h00, 1, 0, rx);
    repeat (250) @(negedge core_clk_in);
    wp_level = 1'b1;
    chk8("committed", 8'h04, status & 8'h8C);
    chk8("busy refused", 8'h04, status);
    chk8("busy opcode", spi_mem_pkg::OP_STATUS_WR, opcode);
    frame(8'hA5, 8'h00, 2, 0, rx);
    chk8("bad opcode", spi_mem_pkg::OP_STATUS_WR, opcode);
    frame(spi_mem_pkg::OP_STATUS_READ, 8'h00, 2, 0, rx);
    chk8("reframed", 8'h04, rx);
    frame(spi_mem_pkg::OP_STATUS_READ, 8'h00, 2, 1, rx);
    chk8("paused read", 8'h04, rx);
    chk8("op strobes", 8'h0E, 8'(op_cnt));
    chk8("data strobes", 8'h04, 8'(data_cnt));
    print_verdict();
  end
endmodule
